/* File: rtl/sfe_params.svh */
`ifndef SFE_PARAMS_SVH
`define SFE_PARAMS_SVH
`define SFE_SECTORS 16
`define SFE_PAGES_PER_SECTOR 256
`define SFE_PAGE_BYTES 256
`define SFE_ADDR_W 20
`define SFE_CMD_WREN 8'h06
`define SFE_CMD_WRDI 8'h04
`define SFE_CMD_RDSR 8'h05
`define SFE_CMD_WRSR 8'h01
`define SFE_CMD_READ 8'h03
`define SFE_CMD_PAGE_WRITE 8'h02
`define SFE_CMD_BLOCK_WIPE 8'hD8
`define SFE_CMD_ARRAY_WIPE 8'hC7
`define SFE_BUSY_CYCLES 16'h0040
`endif

/* File: rtl/sfe_pkg.sv */
package sfe_pkg;
   typedef enum logic [2:0] {
      SFE_CMD = 3'b000,
      SFE_ADDR = 3'b001,
      SFE_DATA_IN = 3'b011,
      SFE_DATA_OUT = 3'b010,
      SFE_STATUS_IN = 3'b110,
      SFE_IGNORE = 3'b111
   } sfe_phase_t;
   typedef enum logic [1:0] {
      SFE_OP_NONE = 2'b00,
      SFE_OP_PROG = 2'b01,
      SFE_OP_WIPE = 2'b11,
      SFE_OP_STAT = 2'b10
   } sfe_op_t;
endpackage : sfe_pkg

/* File: rtl/sfe_sync.sv */
`timescale 1ns/1ps
module sfe_sync
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic din,
   output logic dout
);
   logic meta_reg;
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_reg <= 1'b0;
         dout <= 1'b0;
      end
      else
      begin
         meta_reg <= din;
         dout <= meta_reg;
      end
   end
endmodule : sfe_sync

/* File: rtl/sfe_front_end.sv */
`timescale 1ns/1ps
`include "sfe_params.svh"
module sfe_front_end
#(
   parameter int BUSY_CYCLES = `SFE_BUSY_CYCLES
)
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic sclk,
   input wire logic sel_b,
   input wire logic mosi,
   input wire logic pause_b,
   input wire logic wprot_b,
   output logic miso_o,
   output logic miso_oe,
   output logic active_pwr,
   output logic busy,
   output logic [2:0] protect_range
);
   import sfe_pkg::*;
   logic rst_s1_reg, rst_n;
   logic sclk_s, sel_s, mosi_s, pause_s, wp_s;
   logic sclk_d_reg, sel_d_reg, armed_reg, paused_reg;
   logic [7:0] sr_reg;
   logic [2:0] bit_reg;
   logic [1:0] acnt_reg;
   logic [7:0] cmd_reg;
   logic [`SFE_ADDR_W-1:0] addr_reg;
   logic [7:0] mem [0:`SFE_SECTORS*`SFE_PAGES_PER_SECTOR*`SFE_PAGE_BYTES-1];
   logic [7:0] obyte_reg;
   logic wel_reg, srwd_reg;
   logic [15:0] busy_cnt_reg;
   sfe_phase_t phase_reg;
   sfe_op_t op_reg;
   logic [`SFE_ADDR_W-1:0] op_addr_reg;
   logic [8:0] prog_cnt_reg;
   logic [7:0] prog_buf [0:`SFE_PAGE_BYTES-1];
   logic [7:0] new_stat_reg;
   logic rise, fall, sel_fall, sel_rise, sclk_ok;
   logic [7:0] byte_in;
   logic last_bit;
   logic [3:0] sect;
   logic prot_hit;

   // reset release through two flops
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rst_s1_reg <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_s1_reg <= 1'b1;
         rst_n <= rst_s1_reg;
      end
   end

   sfe_sync u_s_sclk (.sys_clk(sys_clk), .rst_n(rst_n), .din(sclk), .dout(sclk_s));
   sfe_sync u_s_sel (.sys_clk(sys_clk), .rst_n(rst_n), .din(sel_b), .dout(sel_s));
   sfe_sync u_s_mosi (.sys_clk(sys_clk), .rst_n(rst_n), .din(mosi), .dout(mosi_s));
   sfe_sync u_s_pause (.sys_clk(sys_clk), .rst_n(rst_n), .din(pause_b), .dout(pause_s));
   sfe_sync u_s_wp (.sys_clk(sys_clk), .rst_n(rst_n), .din(wprot_b), .dout(wp_s));

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sclk_d_reg <= 1'b0;
         sel_d_reg <= 1'b1;
      end
      else
      begin
         sclk_d_reg <= sclk_s;
         sel_d_reg <= sel_s;
      end
   end

   // edges seen only while selected and not paused
   assign sclk_ok = !sel_s && !paused_reg;
   assign rise = sclk_s && !sclk_d_reg && sclk_ok;
   assign fall = !sclk_s && sclk_d_reg && sclk_ok;
   assign sel_fall = !sel_s && sel_d_reg;
   assign sel_rise = sel_s && !sel_d_reg;
   assign byte_in = {sr_reg[6:0], mosi_s};
   assign last_bit = rise && (bit_reg == 3'h7);
   assign sect = addr_reg[`SFE_ADDR_W-1 -: 4];
   // protected upper region: 1,2,4,8 sectors, all for 5 to 7
   always_comb
   begin
      case (protect_range)
         3'h0: prot_hit = 1'b0;
         3'h1: prot_hit = (sect == 4'hF);
         3'h2: prot_hit = (sect >= 4'hE);
         3'h3: prot_hit = (sect >= 4'hC);
         3'h4: prot_hit = (sect >= 4'h8);
         default: prot_hit = 1'b1;
      endcase
   end

   // pause only honoured while clock low; sclk low level covers both edge cases
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         paused_reg <= 1'b0;
      else if (sel_s)
         paused_reg <= 1'b0;
      else if (!sclk_s && (paused_reg != !pause_s))
         paused_reg <= !pause_s;
   end

   // first select falling edge after reset arms the decoder
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         armed_reg <= 1'b0;
      else if (sel_fall)
         armed_reg <= 1'b1;
   end

   // shifter and command decode
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sr_reg <= 8'h00;
         bit_reg <= 3'h0;
         acnt_reg <= 2'h0;
         cmd_reg <= 8'h00;
         addr_reg <= '0;
         phase_reg <= SFE_CMD;
         prog_cnt_reg <= 9'h000;
         new_stat_reg <= 8'h00;
      end
      else if (sel_s || !armed_reg)
      begin
         bit_reg <= 3'h0;
         phase_reg <= SFE_CMD;
         acnt_reg <= 2'h0;
         if (sel_fall)
            prog_cnt_reg <= 9'h000;
      end
      else if (rise)
      begin
         sr_reg <= byte_in;
         bit_reg <= bit_reg + 3'h1;
         if (bit_reg == 3'h7)
         begin
            case (phase_reg)
               SFE_CMD:
               begin
                  cmd_reg <= byte_in;
                  prog_cnt_reg <= 9'h000;
                  if (busy_cnt_reg != 16'h0000 && byte_in != `SFE_CMD_RDSR)
                     phase_reg <= SFE_IGNORE;
                  else if (byte_in == `SFE_CMD_READ || byte_in == `SFE_CMD_PAGE_WRITE
                           || byte_in == `SFE_CMD_BLOCK_WIPE)
                     phase_reg <= SFE_ADDR;
                  else if (byte_in == `SFE_CMD_RDSR)
                     phase_reg <= SFE_DATA_OUT;
                  else if (byte_in == `SFE_CMD_WRSR)
                     phase_reg <= SFE_STATUS_IN;
                  else
                     phase_reg <= SFE_IGNORE;
               end
               SFE_ADDR:
               begin
                  addr_reg <= {addr_reg[`SFE_ADDR_W-9:0], byte_in};
                  acnt_reg <= acnt_reg + 2'h1;
                  if (acnt_reg == 2'h2)
                     phase_reg <= (cmd_reg == `SFE_CMD_PAGE_WRITE) ? SFE_DATA_IN :
                                  (cmd_reg == `SFE_CMD_READ) ? SFE_DATA_OUT : SFE_IGNORE;
               end
               SFE_DATA_IN:
               begin
                  // page wrap keeps the upper address fixed
                  addr_reg[7:0] <= addr_reg[7:0] + 8'h01;
                  if (prog_cnt_reg != 9'h100)
                     prog_cnt_reg <= prog_cnt_reg + 9'h001;
               end
               SFE_STATUS_IN:
               begin
                  new_stat_reg <= byte_in;
                  phase_reg <= SFE_IGNORE;
               end
               SFE_DATA_OUT:
                  if (cmd_reg == `SFE_CMD_READ)
                     addr_reg <= addr_reg + `SFE_ADDR_W'(1);
               default: phase_reg <= SFE_IGNORE;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (phase_reg == SFE_DATA_IN && last_bit && !sel_s && armed_reg)
         prog_buf[addr_reg[7:0]] <= byte_in;
   end

   // commands commit on deselect only after whole bytes
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wel_reg <= 1'b0;
         srwd_reg <= 1'b0;
         protect_range <= 3'h0;
         busy_cnt_reg <= 16'h0000;
         op_reg <= SFE_OP_NONE;
         op_addr_reg <= '0;
         busy <= 1'b0;
      end
      else if (busy_cnt_reg != 16'h0000)
      begin
         busy_cnt_reg <= busy_cnt_reg - 16'h0001;
         busy <= (busy_cnt_reg != 16'h0001);
      end
      else if (sel_rise && armed_reg && !paused_reg && bit_reg == 3'h0)
      begin
         if (cmd_reg == `SFE_CMD_WREN && phase_reg == SFE_IGNORE)
            wel_reg <= 1'b1;
         else if (cmd_reg == `SFE_CMD_WRDI && phase_reg == SFE_IGNORE)
            wel_reg <= 1'b0;
         else if (wel_reg && cmd_reg == `SFE_CMD_WRSR && phase_reg == SFE_IGNORE)
         begin
            wel_reg <= 1'b0;
            if (wp_s || !srwd_reg)
            begin
               protect_range <= new_stat_reg[4:2];
               srwd_reg <= new_stat_reg[7];
            end
            busy_cnt_reg <= 16'(BUSY_CYCLES);
            busy <= 1'b1;
            op_reg <= SFE_OP_STAT;
         end
         else if (wel_reg && ((cmd_reg == `SFE_CMD_PAGE_WRITE && phase_reg == SFE_DATA_IN
                  && prog_cnt_reg != 9'h000) || (cmd_reg == `SFE_CMD_BLOCK_WIPE && phase_reg == SFE_IGNORE)
                  || (cmd_reg == `SFE_CMD_ARRAY_WIPE && phase_reg == SFE_IGNORE)))
         begin
            wel_reg <= 1'b0;
            if (!(prot_hit && cmd_reg != `SFE_CMD_ARRAY_WIPE) && !(protect_range != 3'h0
                && cmd_reg == `SFE_CMD_ARRAY_WIPE))
            begin
               busy_cnt_reg <= 16'(BUSY_CYCLES);
               busy <= 1'b1;
               op_reg <= (cmd_reg == `SFE_CMD_PAGE_WRITE) ? SFE_OP_PROG : SFE_OP_WIPE;
               op_addr_reg <= (cmd_reg == `SFE_CMD_ARRAY_WIPE) ? '0 : addr_reg;
            end
         end
      end
   end

   // array update at end of internal cycle; wipe loops are costly but storage is flops
   always_ff @(posedge sys_clk)
   begin
      if (busy_cnt_reg == 16'h0001)
      begin
         for (int i = 0; i < `SFE_PAGE_BYTES; i++)
            // buffer is indexed by page offset; the run ends just before the final address
            if (op_reg == SFE_OP_PROG && 9'(i) < prog_cnt_reg)
               mem[{op_addr_reg[`SFE_ADDR_W-1:8], 8'(op_addr_reg[7:0] - prog_cnt_reg[7:0] + 8'(i))}] <=
                  mem[{op_addr_reg[`SFE_ADDR_W-1:8], 8'(op_addr_reg[7:0] - prog_cnt_reg[7:0] + 8'(i))}]
                  & prog_buf[8'(op_addr_reg[7:0] - prog_cnt_reg[7:0] + 8'(i))];
         if (op_reg == SFE_OP_WIPE)
            for (int j = 0; j < `SFE_SECTORS*`SFE_PAGES_PER_SECTOR*`SFE_PAGE_BYTES; j++)
               if (cmd_reg == `SFE_CMD_ARRAY_WIPE || j[19:16] == op_addr_reg[19:16])
                  mem[j] <= 8'hFF;
      end
   end

   // output byte loaded at byte boundary, shifted on falling clock
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         obyte_reg <= 8'h00;
         miso_o <= 1'b0;
      end
      else if (fall && phase_reg == SFE_DATA_OUT)
      begin
         if (bit_reg == 3'h0)
         begin
            if (cmd_reg == `SFE_CMD_RDSR)
            begin
               miso_o <= srwd_reg;
               obyte_reg <= {2'b00, protect_range, wel_reg, busy, 1'b0};
            end
            else
            begin
               miso_o <= mem[addr_reg][7];
               obyte_reg <= {mem[addr_reg][6:0], 1'b0};
            end
         end
         else
         begin
            miso_o <= obyte_reg[7];
            obyte_reg <= {obyte_reg[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         miso_oe <= 1'b0;
         active_pwr <= 1'b0;
      end
      else
      begin
         miso_oe <= !sel_s && !paused_reg && phase_reg == SFE_DATA_OUT;
         active_pwr <= !sel_s || (busy_cnt_reg != 16'h0000);
      end
   end
endmodule : sfe_front_end

/* File: bench/sfe_front_end_sva.sv */
`timescale 1ns/1ps
module sfe_chk
#(
   parameter int BUSY_CYCLES = 64
)
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic sclk,
   input wire logic sel_b,
   input wire logic pause_b,
   input wire logic miso_o,
   input wire logic miso_oe,
   input wire logic active_pwr,
   input wire logic busy,
   input wire logic [2:0] protect_range
);
   logic sclk_reg;
   logic [3:0] fall_age_reg;
   logic [15:0] busy_len_reg;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);
   sequence s_sel_held;
      (!sel_b) [*8];
   endsequence
   // age saturates so a long quiet spell never wraps back into range
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sclk_reg <= 1'b0;
         fall_age_reg <= 4'hF;
         busy_len_reg <= 16'h0000;
      end
      else
      begin
         sclk_reg <= sclk;
         fall_age_reg <= (sclk_reg && !sclk) ? 4'h0 : (fall_age_reg == 4'hF) ? 4'hF : fall_age_reg + 4'h1;
         busy_len_reg <= busy ? busy_len_reg + 16'h0001 : 16'h0000;
      end
   end
   chk_out_on_fall: assert property ($changed(miso_o) && miso_oe && $past(miso_oe) |-> fall_age_reg <= 4'h8)
      else $error("data out moved without a clock fall");
   chk_desel_hiz: assert property ((sel_b) [*4] |-> !miso_oe)
      else $error("data out driven while deselected");
   chk_oe_needs_sel: assert property ($rose(miso_oe) |-> !sel_b && !$past(sel_b))
      else $error("data out enabled without select");
   chk_sel_active: assert property (s_sel_held |-> active_pwr)
      else $error("selected but not active");
   chk_busy_active: assert property (busy && $past(busy) |-> active_pwr)
      else $error("busy but in standby");
   chk_standby_idle: assert property ((sel_b && !busy) [*6] |-> !active_pwr)
      else $error("idle and deselected but active");
   chk_pause_hiz: assert property ((!sel_b && !pause_b) [*8] |-> !miso_oe)
      else $error("data out driven while paused");
   chk_range_commit: assert property (s_sel_held |-> $stable(protect_range))
      else $error("range moved in mid frame");
   chk_busy_span: assert property ($fell(busy) |-> busy_len_reg >= BUSY_CYCLES - 1 && busy_len_reg <= BUSY_CYCLES + 1)
      else $error("busy span wrong");
endmodule : sfe_chk
bind sfe_front_end sfe_chk #(.BUSY_CYCLES(BUSY_CYCLES)) chk_u (.sys_clk(sys_clk), .rst_b(rst_b), .sclk(sclk),
   .sel_b(sel_b), .pause_b(pause_b), .miso_o(miso_o), .miso_oe(miso_oe), .active_pwr(active_pwr), .busy(busy),
   .protect_range(protect_range));

/* File: bench/sfe_master_model.sv */
`timescale 1ns/1ps
module sfe_master_model
(
   input wire logic sys_clk,
   input wire logic miso,
   output logic sclk,
   output logic sel_b,
   output logic mosi,
   output logic pause_b
);
   logic cpol = 1'b0;
   logic oe_seen = 1'b0;
   initial
   begin
      sclk = 1'b0;
      sel_b = 1'b1;
      mosi = 1'b0;
      pause_b = 1'b1;
   end
   task wt(int n);
      repeat (n) @(posedge sys_clk);
   endtask : wt
   task frame_start;
      sclk <= cpol;
      wt(8);
      sel_b <= 1'b0;
      wt(8);
   endtask : frame_start
   task xfer(logic [7:0] tx, int p, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         sclk <= 1'b0;
         mosi <= tx[i];
         wt(8);
         if (i == p)
         begin
            pause_b <= 1'b0;
            wt(8);
            oe_seen = miso;
            sclk <= 1'b1;
            mosi <= ~mosi;
            wt(8);
            sclk <= 1'b0;
            mosi <= tx[i];
            wt(4);
            pause_b <= 1'b1;
            wt(8);
         end
         rx[i] = miso;
         sclk <= 1'b1;
         wt(8);
      end
   endtask : xfer
   task frame_end;
      wt(8);
      sclk <= cpol;
      mosi <= ~mosi;
      wt(8);
      sel_b <= 1'b1;
      wt(8);
   endtask : frame_end
   task pause_set(logic v);
      pause_b <= v;
      wt(8);
   endtask : pause_set
endmodule : sfe_master_model

/* File: bench/serial_flash_spi_front_end_bench.sv */
`timescale 1ns/1ps
`include "sfe_params.svh"
module serial_flash_spi_front_end_bench;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic wprot_b = 1'b1;
   logic sclk, sel_b, mosi, pause_b, miso_o, miso_oe, active_pwr, busy;
   logic [2:0] protect_range;
   wire miso_w = miso_oe ? miso_o : 1'bz;
   int n_errors = 0;
   int checked = 0;
   always #5 sys_clk = ~sys_clk;
   sfe_front_end #(.BUSY_CYCLES(16)) dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .sclk(sclk), .sel_b(sel_b),
      .mosi(mosi), .pause_b(pause_b), .wprot_b(wprot_b), .miso_o(miso_o), .miso_oe(miso_oe),
      .active_pwr(active_pwr), .busy(busy), .protect_range(protect_range));
   sfe_master_model m_u (.sys_clk(sys_clk), .miso(miso_w), .sclk(sclk), .sel_b(sel_b), .mosi(mosi),
      .pause_b(pause_b));
   task give_verdict;
      if (n_errors == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : give_verdict
   task chk(logic [7:0] seen, logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
      end
   endtask : chk
   task idle;
      for (int k = 0; k < 500 && busy !== 1'b0; k++)
         @(posedge sys_clk);
      repeat (2) @(posedge sys_clk);
      chk({7'h00, busy}, 8'h00);
   endtask : idle
   task cmd(logic [7:0] b);
      logic [7:0] rx;
      m_u.frame_start();
      m_u.xfer(b, -1, rx);
      m_u.frame_end();
   endtask : cmd
   task stat(logic [7:0] exp, int p);
      logic [7:0] rx;
      m_u.frame_start();
      m_u.xfer(`SFE_CMD_RDSR, -1, rx);
      m_u.xfer(8'h00, p, rx);
      m_u.frame_end();
      chk(rx, exp);
   endtask : stat
   task wrsr(logic [7:0] v);
      logic [7:0] rx;
      cmd(`SFE_CMD_WREN);
      m_u.frame_start();
      m_u.xfer(`SFE_CMD_WRSR, -1, rx);
      m_u.xfer(v, -1, rx);
      m_u.frame_end();
   endtask : wrsr
   task t_modes;
      for (int md = 0; md < 2; md++)
      begin
         m_u.cpol = md[0];
         stat(8'h00, -1);
         cmd(`SFE_CMD_WREN);
         stat(8'h02, -1);
         cmd(`SFE_CMD_WRDI);
      end
   endtask : t_modes
   task t_wrsr;
      wrsr(8'h94);
      chk({6'h00, busy, active_pwr}, 8'h03);
      idle();
      chk({5'h00, protect_range}, 8'h05);
      chk({7'h00, active_pwr}, 8'h00);
      stat(8'h94, -1);
      wprot_b <= 1'b0;
      wrsr(8'h00);
      idle();
      chk({5'h00, protect_range}, 8'h05);
      wprot_b <= 1'b1;
      wrsr(8'h00);
      idle();
      chk({5'h00, protect_range}, 8'h00);
   endtask : t_wrsr
   task t_pause;
      m_u.cpol = 1'b0;
      cmd(`SFE_CMD_WREN);
      stat(8'h02, 3);
      chk({7'h00, m_u.oe_seen}, {7'h00, 1'bz});
      m_u.frame_start();
      m_u.pause_set(1'b0);
      m_u.frame_end();
      m_u.pause_set(1'b1);
      stat(8'h02, -1);
   endtask : t_pause
   // last pass skips the enable, so the write must be refused
   task t_ops;
      logic [7:0] rx;
      logic [7:0] op;
      for (int k = 0; k < 4; k++)
      begin
         op = k == 1 ? `SFE_CMD_BLOCK_WIPE : k == 2 ? `SFE_CMD_ARRAY_WIPE : `SFE_CMD_PAGE_WRITE;
         if (k != 3)
            cmd(`SFE_CMD_WREN);
         m_u.frame_start();
         m_u.xfer(op, -1, rx);
         for (int j = 0; j < 3 && k != 2; j++)
            m_u.xfer(8'h0F, -1, rx);
         if (k != 1 && k != 2)
            m_u.xfer(8'hA5, -1, rx);
         m_u.frame_end();
         chk({7'h00, busy}, {7'h00, k != 3});
         idle();
      end
      cmd(`SFE_CMD_WREN);
      m_u.frame_start();
      m_u.xfer(`SFE_CMD_PAGE_WRITE, -1, rx);
      for (int j = 0; j < 3; j++)
         m_u.xfer(8'h0F, -1, rx);
      m_u.xfer(8'h3C, -1, rx);
      m_u.frame_end();
      idle();
      m_u.frame_start();
      m_u.xfer(`SFE_CMD_READ, -1, rx);
      for (int j = 0; j < 3; j++)
         m_u.xfer(8'h0F, -1, rx);
      m_u.xfer(8'h00, -1, rx);
      chk(rx, 8'h3C);
      m_u.xfer(8'h00, -1, rx);
      chk(rx, 8'hFF);
      m_u.frame_end();
   endtask : t_ops
   initial
   begin
      repeat (8) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (6) @(posedge sys_clk);
      chk({2'b00, miso_oe, active_pwr, busy, protect_range}, 8'h00);
      t_modes();
      t_wrsr();
      t_pause();
      t_ops();
      give_verdict();
   end
   initial
   begin
      repeat (100000) @(posedge sys_clk);
      n_errors++;
      give_verdict();
   end
endmodule : serial_flash_spi_front_end_bench
